// [bench/pmc_monitor.sv]
// Purpose: Port-level assertions for the power mode block.
// Assumes: Mode and gates are registered outputs.
// Notes:   Bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module pmc_monitor
    import pmc_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire pmc_gates_t gates_out,
    input wire pmc_mode_t  mode_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    AST_RESET_ACTIVE: assert property ($fell(reset_in) |-> mode_out == PMC_ACTIVE)
        else $error("not active after reset");
    AST_ACTIVE_OSC: assert property (
        mode_out == PMC_ACTIVE && $past(mode_out) == PMC_ACTIVE && !$past(reset_in)
        && !$past(reset_in, 2) |-> gates_out.osc_on)
        else $error("oscillator off in active");
    AST_HALT_QUIET: assert property (
        mode_out == PMC_HALT && $past(mode_out) == PMC_HALT |-> !(gates_out.sys_tick
        || gates_out.slow_tick || gates_out.timer_tick || gates_out.pll_on))
        else $error("clock running in halt");
    AST_HALT_MODULES: assert property (
        mode_out == PMC_HALT && $past(mode_out) == PMC_HALT |-> !(gates_out.aux1_tick
        || gates_out.aux2_tick || gates_out.usb_clk_en || gates_out.cpu_run))
        else $error("module clock running in halt");
    AST_IDLE_STOP: assert property (
        mode_out == PMC_IDLE && $past(mode_out) == PMC_IDLE
        |-> !gates_out.sys_tick && !gates_out.cpu_run)
        else $error("system clock in idle");
    AST_IDLE_TIMER: assert property (
        mode_out == PMC_IDLE |-> gates_out.timer_tick == gates_out.slow_tick)
        else $error("timer not on slow clock in idle");
    AST_SAVE_SYS: assert property (
        mode_out == PMC_SAVE && $past(mode_out) == PMC_SAVE
        |-> gates_out.sys_tick == gates_out.slow_tick)
        else $error("system clock not slow in save");
    AST_SLOW_GAP: assert property (gates_out.slow_tick |=> !gates_out.slow_tick)
        else $error("slow tick too close");
endmodule : pmc_monitor

bind pmc_top pmc_monitor i_mon (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .gates_out (gates_out),
    .mode_out  (mode_out)
);
`default_nettype wire

// [bench/pmc_osc_model.sv]
// Purpose: Oscillator and PLL model that feeds the power mode block.
// Assumes: Oscillator stability follows each enable after a short start-up; PLL stability follows its enable at once.
// Notes:   The low-frequency clock runs free in every mode.
`timescale 1ns/1ps
`default_nettype none
module pmc_osc_model
    import pmc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire pmc_gates_t gates_in,
    output var  logic       lfo_clk_out,
    output var  logic       main_stable_out,
    output var  logic       pll_stable_out
);
    logic [2:0] start_reg = 3'h0;

    initial lfo_clk_out = 1'b0;
    always #15259 lfo_clk_out = ~lfo_clk_out;

    // Start-up count restarts whenever the oscillator is switched off.
    always_ff @(posedge clk_in)
    begin
        if (!gates_in.osc_on)
            start_reg <= 3'h0;
        else if (start_reg != 3'h7)
            start_reg <= start_reg + 3'h1;
    end

    assign main_stable_out = start_reg == 3'h7;
    assign pll_stable_out  = gates_in.pll_on & main_stable_out;
endmodule : pmc_osc_model
`default_nettype wire

// [bench/pmc_top_tb_top.sv]
// Purpose: Self-checking bench for the power mode and prescaler block.
// Assumes: The oscillator model reports stability a few cycles after enable.
// Notes:   Every wait is bounded and a cycle ceiling cuts hangs short.
`timescale 1ns/1ps
`default_nettype none
module pmc_top_tb_top
    import pmc_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic        wakeup = 1'b0;
    logic        cpu_wait = 1'b0;
    logic        cpu_irq = 1'b0;
    logic        link_sleep = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, lfo_clk, main_stable, pll_stable;
    pmc_gates_t  gates;
    pmc_mode_t   mode;
    int          err_count = 0;
    int          checks = 0;
    int          cycles = 0;

    pmc_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .lfo_clk_in(lfo_clk), .main_stable_in(main_stable), .pll_stable_in(pll_stable),
        .wakeup_in(wakeup), .cpu_wait_in(cpu_wait), .cpu_irq_in(cpu_irq),
        .link_sleep_in(link_sleep), .gates_out(gates), .mode_out(mode));
    pmc_osc_model i_osc (.clk_in(clk_in), .gates_in(gates), .lfo_clk_out(lfo_clk),
        .main_stable_out(main_stable), .pll_stable_out(pll_stable));

    initial forever #25 clk_in = ~clk_in;

    task automatic finish_test();
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    // Setup cycle, then access phase held until ready is sampled high.
    task automatic apb(input logic w, input logic [23:0] idx, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_in);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {6'h00, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge clk_in);
        chk({31'h0, pready}, 32'h1, "ready");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [23:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, idx, d, rd, e);
    endtask : wr

    task automatic rdchk(input logic [23:0] idx, input logic [7:0] exp, input string msg);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, idx, 8'h00, rd, e);
        chk(rd, {24'h00_0000, exp}, msg);
    endtask : rdchk

    function automatic logic tick(input int sel);
        return sel == 0 ? gates.slow_tick : sel == 1 ? gates.aux1_tick : gates.aux2_tick;
    endfunction : tick

    // Synchronises to one tick, then counts cycles to the next.
    task automatic period(input int sel, input int exp, input string msg);
        int n;
        for (n = 0; n < 1000 && tick(sel) !== 1'b1; n++) @(posedge clk_in);
        @(posedge clk_in);
        for (n = 1; n < 1000 && tick(sel) !== 1'b1; n++) @(posedge clk_in);
        chk(n, exp, msg);
    endtask : period

    task automatic wait_instr();
        cpu_wait <= 1'b1;
        @(posedge clk_in);
        cpu_wait <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask : wait_instr

    task automatic t_prescalers();
        chk(mode, PMC_ACTIVE, "reset mode");
        chk(gates.osc_on, 1'b1, "osc in active");
        rdchk(PMC_IDX_SLOW_DIV, 8'hb6, "slow div reset");
        rdchk(PMC_IDX_AUX_DIV, 8'hff, "aux div reset");
        period(0, 366, "slow reset period");
        wr(PMC_IDX_SLOW_DIV, 8'h03);
        period(0, 8, "slow period");
        wr(PMC_IDX_CLK_RESET_CTRL, 8'h1a);
        wr(PMC_IDX_AUX_DIV, 8'h20);
        period(1, 1, "aux one period");
        period(2, 3, "aux two period");
        chk(gates.pll_on, 1'b1, "pll powered up");
        chk(gates.sys_from_pll, 1'b0, "system on main clock");
    endtask : t_prescalers

    task automatic t_modes();
        int k;
        wr(PMC_IDX_MODE_CTRL, 8'h01);
        repeat (3) @(posedge clk_in);
        chk(mode, PMC_SAVE, "save mode");
        rdchk(PMC_IDX_MODE_CTRL, 8'h01, "save bit");
        wr(PMC_IDX_MODE_CTRL, 8'h00);
        repeat (3) @(posedge clk_in);
        chk(mode, PMC_ACTIVE, "save exit");
        wr(PMC_IDX_MODE_CTRL, 8'h12);
        repeat (3) @(posedge clk_in);
        chk(mode, PMC_ACTIVE, "idle before wait");
        wait_instr();
        chk(mode, PMC_IDLE, "idle mode");
        period(0, 8, "slow in idle");
        chk(gates.osc_on, 1'b1, "osc kept for slow clock");
        wakeup <= 1'b1;
        repeat (4) @(posedge clk_in);
        wakeup <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk(mode, PMC_ACTIVE, "idle wake");
        chk(gates.cpu_run, 1'b0, "cpu held by wait");
        cpu_irq <= 1'b1;
        @(posedge clk_in);
        cpu_irq <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk(gates.cpu_run, 1'b1, "cpu resumes on interrupt");
        wr(PMC_IDX_CLK_RESET_CTRL, 8'h0a);
        wr(PMC_IDX_MODE_CTRL, 8'h0c);
        wait_instr();
        @(posedge clk_in);
        chk(mode, PMC_HALT, "halt mode");
        chk(gates.osc_on, 1'b0, "osc in halt");
        wakeup <= 1'b1;
        for (k = 0; k < 64 && mode !== PMC_ACTIVE; k++) @(posedge clk_in);
        wakeup <= 1'b0;
        chk(mode, PMC_ACTIVE, "halt wake");
        rdchk(PMC_IDX_SLOW_DIV, 8'h03, "slow div kept");
        rdchk(PMC_IDX_AUX_DIV, 8'h20, "aux div kept");
    endtask : t_modes

    task automatic t_hw_gate();
        logic [31:0] rd;
        logic        e;
        apb(1'b0, 24'hff_fc50, 8'h00, rd, e);
        chk(e, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        wr(PMC_IDX_CLK_RESET_CTRL, 8'h1f);
        link_sleep <= 1'b1;
        wr(PMC_IDX_MODE_CTRL, 8'h41);
        repeat (6) @(posedge clk_in);
        chk(mode, PMC_SAVE, "save on low clock");
        chk(gates.osc_on, 1'b0, "hw osc gate");
        chk(gates.pll_on, 1'b0, "pll powered down");
        link_sleep <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk(gates.osc_on, 1'b1, "link awake");
        wr(PMC_IDX_MODE_CTRL, 8'h51);
        repeat (4) @(posedge clk_in);
        chk(gates.osc_on, 1'b0, "sw osc disable wins");
        wr(PMC_IDX_MODE_CTRL, 8'h00);
    endtask : t_hw_gate

    initial
    begin
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        t_prescalers();
        t_modes();
        t_hw_gate();
        finish_test();
    end
endmodule : pmc_top_tb_top
`default_nettype wire

// [logic/pmc_pkg.sv]
// Purpose: Shared constants and types of the power mode and clock prescaler block.
// Assumes: APB with 32-bit data; register index times four gives the byte address.
// Notes:   Register widths are one byte; upper data bits read as zero.
package pmc_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [23:0] PMC_IDX_CLK_RESET_CTRL = 24'hff_fc40;
    localparam logic [23:0] PMC_IDX_SLOW_DIV       = 24'hff_fc44;
    localparam logic [23:0] PMC_IDX_AUX_DIV        = 24'hff_fc46;
    localparam logic [23:0] PMC_IDX_MODE_CTRL      = 24'hff_fc60;
    localparam logic [23:0] PMC_IDX_MODE_STATUS    = 24'hff_fc62;

    // Reset values.
    localparam logic [7:0] PMC_RST_SLOW_DIV   = 8'hb6;
    localparam logic [7:0] PMC_RST_AUX_DIV    = 8'hff;
    localparam logic [7:0] PMC_RST_CLK_RESET  = 8'h26;
    localparam logic [7:0] PMC_RST_MODE_CTRL  = 8'h00;

    // Clock and reset control fields.
    localparam int PMC_CR_SLOW_SEL  = 0;
    localparam int PMC_CR_FAST_MAIN = 1;
    localparam int PMC_CR_PLL_PWD   = 2;
    localparam int PMC_CR_AUX1_EN   = 3;
    localparam int PMC_CR_AUX2_EN   = 4;
    localparam int PMC_CR_POR       = 5;

    // Power mode control fields.
    localparam int PMC_MC_SAVE_REQ  = 0;
    localparam int PMC_MC_IDLE      = 1;
    localparam int PMC_MC_HALT      = 2;
    localparam int PMC_MC_WAIT_BEF  = 3;
    localparam int PMC_MC_OSC_DIS   = 4;
    localparam int PMC_MC_PLL_DIS   = 5;
    localparam int PMC_MC_HW_OSC    = 6;
    localparam int PMC_MC_HW_PLL    = 7;

    // Auxiliary divisor field positions.
    localparam int PMC_AUX1_LSB = 0;
    localparam int PMC_AUX2_LSB = 4;
    localparam int PMC_AUX_W    = 4;

    typedef enum logic [1:0] {
        PMC_ACTIVE,
        PMC_SAVE,
        PMC_IDLE,
        PMC_HALT
    } pmc_mode_t;

    // Clock enables handed to the clock consumers, one cycle per tick.
    typedef struct packed {
        logic osc_on;
        logic pll_on;
        logic sys_tick;
        logic sys_from_pll;
        logic cpu_run;
        logic timer_tick;
        logic slow_tick;
        logic aux1_tick;
        logic aux2_tick;
        logic usb_clk_en;
    } pmc_gates_t;

endpackage : pmc_pkg

// [logic/pmc_top.sv]
// Purpose: Power mode controller with slow-clock and auxiliary-clock prescalers.
// Assumes: clk_in is the Main Clock domain; every derived clock is a one-cycle enable.
// Notes:   Main Clock ticks count only while the oscillator is on and reported stable.
// How it works
// - Slow tick every two times slow divisor plus two Main Clock ticks.
// - Slow divisor register resets to B6h.
// - Two auxiliary prescalers, both divisor fields share one byte register.
// - Auxiliary divisor register resets to FFh.
// - Active: oscillator on, system clock from Main Clock or divided PLL.
// - Reset leaves the device in Active mode.
// - Power Save: system clock is the Slow Clock.
// - Idle: system clock stopped, timer keeps Slow Clock.
// - Halt: system, Main and Slow clocks stopped, oscillator and PLL off.
// - Halt keeps every register value intact.
// - Low-frequency input always sampled; Slow Clock silent in Halt.
// - Oscillator disable only honoured while Slow Clock uses low-frequency source.
// - Auxiliary clocks run in low-power modes only while Main Clock runs.
// - USB from PLL, link/audio from aux one, transcoder/converter aux two.
// - Wake-up events are processed in Idle and Halt.
// - After WAIT the CPU stays stopped until an interrupt arrives.
// - Link controller sleep lets hardware gating stop oscillator and PLL.
// - Hardware gate bits act in Save and Idle while link sleeps.
// - Software disable bits override hardware gating in Save and Idle.
// - Active forces oscillator on and PLL on unless its power-down bit is set, Halt forces them off until a wake-up event restarts the oscillator.
// - PLL power-down bit stops PLL in every mode, oscillator untouched.
// - Slow source select: 0 prescaled Main Clock, 1 low-frequency oscillator.
// - Power-save request starts switch; reads 1 only once the switch is done.
`timescale 1ns/1ps
`default_nettype none

module pmc_top
    import pmc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output var  logic [31:0] prdata_out,
    output var  logic        pready_out,
    output var  logic        pslverr_out,
    input  wire logic        lfo_clk_in,
    input  wire logic        main_stable_in,
    input  wire logic        pll_stable_in,
    input  wire logic        wakeup_in,
    input  wire logic        cpu_wait_in,
    input  wire logic        cpu_irq_in,
    input  wire logic        link_sleep_in,
    output var  pmc_gates_t  gates_out,
    output var  pmc_mode_t   mode_out
);

    // Synchronisers for inputs from outside the clock domain.
    logic [1:0] lfo_sync_reg;
    logic [1:0] stable_sync_reg;
    logic [1:0] pll_sync_reg;
    logic [1:0] wake_sync_reg;
    logic       lfo_prev_reg;

    logic [7:0] slow_div_reg;
    logic [7:0] aux_div_reg;
    logic [7:0] clk_ctrl_reg;
    logic [7:0] mode_ctrl_reg;
    pmc_mode_t  mode_reg;
    logic       save_pend_reg;
    logic       cpu_wait_reg;
    logic [8:0] slow_cnt_reg;
    logic [3:0] aux1_cnt_reg;
    logic [3:0] aux2_cnt_reg;
    logic       osc_on_reg;
    logic       pll_on_reg;

    logic        main_stable;
    logic        pll_stable;
    logic        wake_evt;
    logic        lfo_tick;
    logic        main_tick;
    logic        slow_pre_tick;
    logic        slow_tick;
    logic        aux1_tick;
    logic        aux2_tick;
    logic        setup;
    logic        wr_en;
    logic        rd_hit;
    logic [23:0] reg_idx;
    logic [7:0]  rd_byte;
    logic [7:0]  wdata;
    logic        osc_want;
    logic        pll_want;
    logic [8:0]  slow_top;
    logic        in_low;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            lfo_sync_reg    <= 2'h0;
            stable_sync_reg <= 2'h0;
            pll_sync_reg    <= 2'h0;
            wake_sync_reg   <= 2'h0;
            lfo_prev_reg    <= 1'b0;
        end
        else
        begin
            lfo_sync_reg    <= {lfo_sync_reg[0], lfo_clk_in};
            stable_sync_reg <= {stable_sync_reg[0], main_stable_in};
            pll_sync_reg    <= {pll_sync_reg[0], pll_stable_in};
            wake_sync_reg   <= {wake_sync_reg[0], wakeup_in};
            lfo_prev_reg    <= lfo_sync_reg[1];
        end
    end

    assign main_stable = stable_sync_reg[1];
    assign pll_stable  = pll_sync_reg[1] & pll_on_reg;
    assign wake_evt    = wake_sync_reg[1];
    assign lfo_tick    = lfo_sync_reg[1] & ~lfo_prev_reg;
    assign main_tick   = osc_on_reg & main_stable;
    assign in_low      = (mode_reg == PMC_SAVE) || (mode_reg == PMC_IDLE);

    // APB decode: one setup cycle, then one access cycle with pready raised.
    assign reg_idx = paddr_in[25:2];
    assign setup   = psel_in & ~penable_in;
    assign wr_en   = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
    assign wdata   = pwdata_in[7:0];
    assign slow_top = {slow_div_reg, 1'b1};

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (reg_idx)
            PMC_IDX_CLK_RESET_CTRL: rd_byte = clk_ctrl_reg;
            PMC_IDX_SLOW_DIV:       rd_byte = slow_div_reg;
            PMC_IDX_AUX_DIV:        rd_byte = aux_div_reg;
            PMC_IDX_MODE_CTRL:
            begin
                rd_byte = mode_ctrl_reg;
                rd_byte[PMC_MC_SAVE_REQ] = (mode_reg == PMC_SAVE);
            end
            PMC_IDX_MODE_STATUS:
                rd_byte = {2'h0, cpu_wait_reg, main_stable, pll_on_reg, osc_on_reg,
                           mode_reg};
            default:                rd_hit  = 1'b0;
        endcase
        if (paddr_in[1:0] != 2'h0 || paddr_in[31:26] != 6'h00)
        begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end
        else
        begin
            pready_out  <= setup;
            pslverr_out <= setup & ~rd_hit;
            if (setup)
            begin
                prdata_out <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end
        end
    end

    // Prescaler divisor registers.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            slow_div_reg <= PMC_RST_SLOW_DIV;
            aux_div_reg  <= PMC_RST_AUX_DIV;
        end
        else if (wr_en)
        begin
            if (reg_idx == PMC_IDX_SLOW_DIV)
            begin
                slow_div_reg <= wdata;
            end
            if (reg_idx == PMC_IDX_AUX_DIV)
            begin
                aux_div_reg <= wdata;
            end
        end
    end

    // Clock and reset control with its guarded bits.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            clk_ctrl_reg <= PMC_RST_CLK_RESET;
        end
        else if (wr_en && reg_idx == PMC_IDX_CLK_RESET_CTRL)
        begin
            clk_ctrl_reg[PMC_CR_SLOW_SEL] <= wdata[PMC_CR_SLOW_SEL];
            clk_ctrl_reg[PMC_CR_AUX1_EN]  <= wdata[PMC_CR_AUX1_EN];
            clk_ctrl_reg[PMC_CR_AUX2_EN]  <= wdata[PMC_CR_AUX2_EN];
            // Power-on flag can only be cleared.
            clk_ctrl_reg[PMC_CR_POR] <= clk_ctrl_reg[PMC_CR_POR] & wdata[PMC_CR_POR];
            // Switching to the PLL needs it powered and settled.
            if (wdata[PMC_CR_FAST_MAIN] || (!clk_ctrl_reg[PMC_CR_PLL_PWD] && pll_stable))
            begin
                clk_ctrl_reg[PMC_CR_FAST_MAIN] <= wdata[PMC_CR_FAST_MAIN];
            end
            // Powering down the PLL needs the system clock on the Main Clock.
            if (!wdata[PMC_CR_PLL_PWD] || clk_ctrl_reg[PMC_CR_FAST_MAIN])
            begin
                clk_ctrl_reg[PMC_CR_PLL_PWD] <= wdata[PMC_CR_PLL_PWD];
            end
        end
    end

    // Mode control register; the mode request bits are consumed by the mode machine.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            mode_ctrl_reg <= PMC_RST_MODE_CTRL;
            save_pend_reg <= 1'b0;
        end
        else
        begin
            if (wr_en && reg_idx == PMC_IDX_MODE_CTRL)
            begin
                mode_ctrl_reg <= wdata;
                save_pend_reg <= wdata[PMC_MC_SAVE_REQ] & (mode_reg == PMC_ACTIVE);
            end
            else if (mode_reg != PMC_ACTIVE || wake_evt)
            begin
                save_pend_reg <= 1'b0;
            end
            if (wake_evt && !(wr_en && reg_idx == PMC_IDX_MODE_CTRL))
            begin
                mode_ctrl_reg[PMC_MC_SAVE_REQ] <= 1'b0;
                mode_ctrl_reg[PMC_MC_IDLE]     <= 1'b0;
                if (mode_reg != PMC_HALT || main_stable)
                begin
                    mode_ctrl_reg[PMC_MC_HALT] <= 1'b0;
                end
            end
        end
    end

    // Power mode machine.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            mode_reg <= PMC_ACTIVE;
        end
        else
        begin
            unique case (mode_reg)
                PMC_ACTIVE:
                begin
                    if (cpu_wait_in && mode_ctrl_reg[PMC_MC_HALT]
                        && mode_ctrl_reg[PMC_MC_WAIT_BEF])
                    begin
                        mode_reg <= PMC_HALT;
                    end
                    else if (cpu_wait_in && mode_ctrl_reg[PMC_MC_IDLE])
                    begin
                        mode_reg <= PMC_IDLE;
                    end
                    else if (save_pend_reg
                             && (!mode_ctrl_reg[PMC_MC_WAIT_BEF] || cpu_wait_in))
                    begin
                        mode_reg <= PMC_SAVE;
                    end
                end
                PMC_SAVE:
                begin
                    if (wake_evt || (wr_en && reg_idx == PMC_IDX_MODE_CTRL
                                     && !wdata[PMC_MC_SAVE_REQ]))
                    begin
                        mode_reg <= PMC_ACTIVE;
                    end
                end
                PMC_IDLE:
                begin
                    if (wake_evt)
                    begin
                        mode_reg <= PMC_ACTIVE;
                    end
                end
                PMC_HALT:
                begin
                    // Leave once the restarted oscillator has settled, or at once if the halt request bit is clear.
                    if (!mode_ctrl_reg[PMC_MC_HALT] || (wake_evt && main_stable))
                    begin
                        mode_reg <= PMC_ACTIVE;
                    end
                end
            endcase
        end
    end

    // Oscillator and PLL requests from mode, disable bits and hardware gating.
    always_comb
    begin
        osc_want = 1'b1;
        pll_want = 1'b1;
        unique case (mode_reg)
            PMC_ACTIVE:
            begin
                osc_want = 1'b1;
                pll_want = 1'b1;
            end
            PMC_HALT:
            begin
                osc_want = 1'b0;
                pll_want = 1'b0;
            end
            default:
            begin
                // Software disables win over the link controller's gating.
                osc_want = !(mode_ctrl_reg[PMC_MC_OSC_DIS]
                             || (mode_ctrl_reg[PMC_MC_HW_OSC] && link_sleep_in));
                pll_want = !(mode_ctrl_reg[PMC_MC_PLL_DIS]
                             || (mode_ctrl_reg[PMC_MC_HW_PLL] && link_sleep_in));
                // The oscillator may stop only if the Slow Clock has another source.
                if (!clk_ctrl_reg[PMC_CR_SLOW_SEL])
                begin
                    osc_want = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            osc_on_reg <= 1'b1;
            pll_on_reg <= 1'b0;
        end
        else
        begin
            osc_on_reg <= osc_want | (mode_reg == PMC_HALT && wake_evt);
            pll_on_reg <= pll_want & ~clk_ctrl_reg[PMC_CR_PLL_PWD];
        end
    end

    // Slow Clock prescaler.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            slow_cnt_reg <= 9'h000;
        end
        else if (main_tick)
        begin
            slow_cnt_reg <= (slow_cnt_reg >= slow_top) ? 9'h000 : slow_cnt_reg + 9'h001;
        end
    end

    assign slow_pre_tick = main_tick && (slow_cnt_reg >= slow_top);
    assign slow_tick = (mode_reg != PMC_HALT)
                       && (clk_ctrl_reg[PMC_CR_SLOW_SEL] ? lfo_tick : slow_pre_tick);

    // Auxiliary prescalers; both stop with the Main Clock.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            aux1_cnt_reg <= 4'h0;
            aux2_cnt_reg <= 4'h0;
        end
        else if (main_tick)
        begin
            aux1_cnt_reg <= aux1_tick ? 4'h0 : aux1_cnt_reg + 4'h1;
            aux2_cnt_reg <= aux2_tick ? 4'h0 : aux2_cnt_reg + 4'h1;
        end
    end

    assign aux1_tick = main_tick
                       && aux1_cnt_reg >= aux_div_reg[PMC_AUX1_LSB +: PMC_AUX_W];
    assign aux2_tick = main_tick
                       && aux2_cnt_reg >= aux_div_reg[PMC_AUX2_LSB +: PMC_AUX_W];

    // WAIT holds the CPU until an interrupt; a new WAIT wins over a same-cycle interrupt.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            cpu_wait_reg <= 1'b0;
        end
        else if (cpu_wait_in)
        begin
            cpu_wait_reg <= 1'b1;
        end
        else if (cpu_irq_in)
        begin
            cpu_wait_reg <= 1'b0;
        end
    end

    // Registered clock enables toward the consumers; registers persist in every mode.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            gates_out <= '0;
            mode_out  <= PMC_ACTIVE;
        end
        else
        begin
            mode_out             <= mode_reg;
            gates_out.osc_on     <= osc_on_reg;
            gates_out.pll_on     <= pll_on_reg;
            gates_out.slow_tick  <= slow_tick;
            gates_out.timer_tick <= slow_tick;
            gates_out.sys_from_pll <= (mode_reg == PMC_ACTIVE)
                                      && !clk_ctrl_reg[PMC_CR_FAST_MAIN];
            unique case (mode_reg)
                PMC_ACTIVE: gates_out.sys_tick <= clk_ctrl_reg[PMC_CR_FAST_MAIN]
                                                  ? main_tick : pll_stable;
                PMC_SAVE:   gates_out.sys_tick <= slow_tick;
                PMC_IDLE:   gates_out.sys_tick <= 1'b0;
                PMC_HALT:   gates_out.sys_tick <= 1'b0;
            endcase
            gates_out.cpu_run <= !cpu_wait_reg
                                 && (mode_reg == PMC_ACTIVE || mode_reg == PMC_SAVE);
            // Auxiliary clocks keep running in Save and Idle while the Main Clock does.
            gates_out.aux1_tick <= aux1_tick && clk_ctrl_reg[PMC_CR_AUX1_EN]
                                   && (mode_reg != PMC_HALT);
            // The converter on this clock is starved in Halt and disabled while its enable bit is clear.
            gates_out.aux2_tick <= aux2_tick && clk_ctrl_reg[PMC_CR_AUX2_EN]
                                   && (mode_reg != PMC_HALT);
            gates_out.usb_clk_en <= pll_stable && (mode_reg != PMC_HALT);
        end
    end

    logic unused_in_low;
    assign unused_in_low = in_low;

endmodule : pmc_top

`default_nettype wire
